/* File: core/kbd_mouse_wake.sv */
// Keyboard and mouse specific wake detector with APB registers
`timescale 1ns/1ps
module kbd_mouse_wake
  import wake_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC,
  parameter int SPIN_CYCLES = SPIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic bat_por,
  input wire logic soft_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic porta_valid,
  input wire logic [7:0] porta_byte,
  input wire logic portb_valid,
  input wire logic [7:0] portb_byte,
  input wire mouse_evt_t porta_mouse,
  input wire mouse_evt_t portb_mouse,
  output logic wake_pme,
  output logic key_power_button_flag,
  output logic spinup_done
);
  initial begin
    if (STEP_CYCLES < 1 || SPIN_CYCLES < 1) begin
      $error("Cycle counts must be at least one");
    end
  end
  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  logic [17:0] in_s1_q, in_s2_q;
  logic bat_s1_q, bat_s2_q, rst_s1_q, rst_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      bat_s1_q <= 1'b0;
      bat_s2_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else if (clk_en) begin
      in_s1_q <= {porta_valid, porta_byte, portb_valid, portb_byte};
      in_s2_q <= in_s1_q;
      bat_s1_q <= bat_por;
      bat_s2_q <= bat_s1_q;
      rst_s1_q <= soft_rst;
      rst_s2_q <= rst_s1_q;
    end
  end
  // -------------------------------------------------------------------------
  // Mouse bits are quasi-static; synchronise as a bundle
  // -------------------------------------------------------------------------
  mouse_evt_t ma_s1_q, ma_s2_q, mb_s1_q, mb_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ma_s1_q <= '0;
      ma_s2_q <= '0;
      mb_s1_q <= '0;
      mb_s2_q <= '0;
    end else if (clk_en) begin
      ma_s1_q <= porta_mouse;
      ma_s2_q <= ma_s1_q;
      mb_s1_q <= portb_mouse;
      mb_s2_q <= mb_s1_q;
    end
  end
  // -------------------------------------------------------------------------
  // Registers and APB slave
  // -------------------------------------------------------------------------
  logic [7:0] mctl_q, mctl_d, dbl_q, dbl_d, kcfg_q, kcfg_d;
  logic [7:0] cmp_q [5], cmp_d [5];
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic acc, wr, mlock, klock, hit;
  logic [7:0] wb, idx;
  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign wb = pwdata[7:0];
  assign idx = paddr[9:2];
  assign mlock = mctl_q[LOCK_BIT];
  assign klock = kcfg_q[LOCK_BIT];
  always_comb begin
    mctl_d = mctl_q;
    dbl_d = dbl_q;
    kcfg_d = kcfg_q;
    cmp_d = cmp_q;
    prdata_d = prdata;
    pready_d = acc;
    pslverr_d = 1'b0;
    hit = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
    if (bat_s2_q) begin
      mctl_d = RST_MOUSE_CTRL;
      dbl_d = RST_DBL_CLICK;
      kcfg_d = RST_KBD_CFG;
      cmp_d[0] = RST_MAKE1;
      cmp_d[1] = RST_MAKE2;
      cmp_d[2] = RST_BRK1;
      cmp_d[3] = RST_BRK2;
      cmp_d[4] = RST_BRK3;
    end else if (rst_s2_q) begin
      mctl_d[LOCK_BIT] = 1'b0;
      kcfg_d[LOCK_BIT] = 1'b0;
    end else if (acc) begin
      prdata_d = '0;
      if (hit && idx == IDX_MOUSE_CTRL) begin
        prdata_d[7:0] = mctl_q;
        if (wr && !mlock) begin
          mctl_d = wb & (MOUSE_CTRL_MASK | 8'h80);
        end
      end else if (hit && idx == IDX_DBL_CLICK) begin
        prdata_d[7:0] = dbl_q;
        if (wr && !mlock) begin
          dbl_d = wb & (DBL_CLICK_MASK | DBL_SPIN_MASK);
        end
      end else if (hit && idx >= IDX_MAKE1 && idx <= IDX_BRK3) begin
        prdata_d[7:0] = cmp_q[3'(idx - IDX_MAKE1)];
        if (wr && !klock) begin
          cmp_d[3'(idx - IDX_MAKE1)] = wb;
        end
      end else if (hit && idx == IDX_KBD_CFG) begin
        prdata_d[7:0] = kcfg_q;
        if (wr && !klock) begin
          kcfg_d = wb & (KBD_CFG_MASK | 8'h80);
        end
      end else if (hit && idx == IDX_STATUS) begin
        prdata_d[2:0] = {spinup_done, key_power_button_flag, wake_pme};
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctl_q <= RST_MOUSE_CTRL;
      dbl_q <= RST_DBL_CLICK;
      kcfg_q <= RST_KBD_CFG;
      cmp_q <= '{RST_MAKE1, RST_MAKE2, RST_BRK1, RST_BRK2, RST_BRK3};
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      mctl_q <= mctl_d;
      dbl_q <= dbl_d;
      kcfg_q <= kcfg_d;
      cmp_q <= cmp_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end
  // -------------------------------------------------------------------------
  // Port exchange
  // -------------------------------------------------------------------------
  logic kv, key_ev;
  logic [7:0] kb;
  mouse_evt_t ms, ms_prev_q;
  always_comb begin
    if (mctl_q[SWAP_BIT]) begin
      kv = in_s2_q[8];
      kb = in_s2_q[7:0];
      ms = ma_s2_q;
    end else begin
      kv = in_s2_q[17];
      kb = in_s2_q[16:9];
      ms = mb_s2_q;
    end
  end
  // -------------------------------------------------------------------------
  // Scan code matcher
  // -------------------------------------------------------------------------
  logic [1:0] mk_pos_q, mk_pos_d, bk_pos_q, bk_pos_d;
  logic kv_q, make_hit, brk_hit, m1, m2, b1, b2, b3, multi;
  scan_type_t st;
  function automatic logic eqw(input logic [7:0] c, input logic [7:0] b);
    eqw = (c == WILDCARD) || (c == b);
  endfunction
  assign st = scan_type_t'(kcfg_q[3:2]);
  assign multi = st == SCAN_S1_MULTI || st == SCAN_S2_MULTI;
  assign key_ev = kv && !kv_q;
  assign m1 = eqw(cmp_q[0], kb);
  assign m2 = eqw(cmp_q[1], kb);
  assign b1 = eqw(cmp_q[2], kb);
  assign b2 = eqw(cmp_q[3], kb);
  assign b3 = eqw(cmp_q[4], kb);
  always_comb begin
    mk_pos_d = mk_pos_q;
    bk_pos_d = bk_pos_q;
    make_hit = 1'b0;
    brk_hit = 1'b0;
    if (key_ev) begin
      if (mk_pos_q == 2'd0) begin
        make_hit = m1 && !multi;
        mk_pos_d = (m1 && multi) ? 2'd1 : 2'd0;
      end else begin
        make_hit = m2;
        mk_pos_d = 2'd0;
      end
      case (bk_pos_q)
        2'd0: begin
          brk_hit = b1 && st == SCAN_S1_SINGLE;
          bk_pos_d = (b1 && st != SCAN_S1_SINGLE) ? 2'd1 : 2'd0;
        end
        2'd1: begin
          brk_hit = b2 && st != SCAN_S2_MULTI;
          bk_pos_d = (b2 && st == SCAN_S2_MULTI) ? 2'd2 : 2'd0;
        end
        default: begin
          brk_hit = b3;
          bk_pos_d = 2'd0;
        end
      endcase
    end
  end
  // -------------------------------------------------------------------------
  // Double-click window, mouse matcher, spin-up timer
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_WAIT} mstate_t;
  mstate_t ms_q, ms_d;
  logic [31:0] tick_q, tick_d, spin_q, spin_d;
  logic [5:0] steps_q, steps_d;
  logic click_l, click_r, click_any, moved, mhit, ktrig;
  logic pme_d, pbf_d, spin_done_d;
  assign click_l = ms.left && !ms_prev_q.left;
  assign click_r = ms.right && !ms_prev_q.right;
  assign click_any = click_l || click_r || (ms.middle && !ms_prev_q.middle);
  assign moved = ms.moved && !ms_prev_q.moved;
  assign ktrig = make_hit;
  always_comb begin
    ms_d = ms_q;
    tick_d = tick_q;
    steps_d = steps_q;
    mhit = 1'b0;
    case (mctl_q[4:2])
      3'b000: mhit = click_any || moved;
      3'b001: mhit = click_l;
      3'b010: mhit = click_r;
      3'b011: mhit = click_any;
      default: mhit = 1'b0;
    endcase
    case (ms_q)
      M_IDLE: begin
        if ((mctl_q[4:2] == 3'b101 && click_l) ||
            (mctl_q[4:2] == 3'b110 && click_r)) begin
          ms_d = M_WAIT;
          tick_d = '0;
          steps_d = '0;
        end
      end
      default: begin
        if ((mctl_q[4:2] == 3'b101 && click_l) ||
            (mctl_q[4:2] == 3'b110 && click_r)) begin
          mhit = 1'b1;
          ms_d = M_IDLE;
        end else if (tick_q == 32'(STEP_CYCLES - 1)) begin
          tick_d = '0;
          steps_d = 6'(steps_q + 6'd1);
          if (steps_q >= dbl_q[5:0]) begin
            ms_d = M_IDLE;
          end
        end else begin
          tick_d = 32'(tick_q + 32'd1);
        end
      end
    endcase
    pme_d = wake_pme || mhit || (ktrig && kcfg_q[4] == 1'b0) ||
            (ktrig && kcfg_q[5]);
    pbf_d = key_power_button_flag;
    if (key_power_button_flag && key_ev) begin
      if (kcfg_q[5:4] == 2'b00 && !make_hit) begin
        pbf_d = 1'b0;
      end else if (kcfg_q[5:4] == 2'b10 && brk_hit) begin
        pbf_d = 1'b0;
      end
    end
    if (ktrig) begin
      pbf_d = 1'b1;
    end
    spin_d = spin_q;
    spin_done_d = spinup_done;
    if (!spinup_done) begin
      if (dbl_q[SPIN_BIT] || spin_q == 32'(SPIN_CYCLES - 1)) begin
        spin_done_d = 1'b1;
      end else begin
        spin_d = 32'(spin_q + 32'd1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mk_pos_q <= '0;
      bk_pos_q <= '0;
      kv_q <= 1'b0;
      ms_prev_q <= '0;
      ms_q <= M_IDLE;
      tick_q <= '0;
      steps_q <= '0;
      spin_q <= '0;
      wake_pme <= 1'b0;
      key_power_button_flag <= 1'b0;
      spinup_done <= 1'b0;
    end else if (clk_en) begin
      mk_pos_q <= mk_pos_d;
      bk_pos_q <= bk_pos_d;
      kv_q <= kv;
      ms_prev_q <= ms;
      ms_q <= ms_d;
      tick_q <= tick_d;
      steps_q <= steps_d;
      spin_q <= spin_d;
      wake_pme <= pme_d;
      key_power_button_flag <= pbf_d;
      spinup_done <= spin_done_d;
    end
  end
  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  mouse_lock_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && mlock && !bat_s2_q && !rst_s2_q |=> $stable(mctl_q))
    else $error("Mouse control changed while locked");
  dbl_lock_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && mlock && !bat_s2_q |=> dbl_q[5:0] == $past(dbl_q[5:0]))
    else $error("Interval changed while locked");
  dbl_bit6_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    dbl_q[6] == 1'b0)
    else $error("Double-click bit 6 not zero");
  mctl_bit5_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mctl_q[5] == 1'b0 && mctl_q[1:0] == 2'b00)
    else $error("Mouse control reserved bits set");
  kbd_lock_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && klock && !bat_s2_q && !rst_s2_q |=> $stable(kcfg_q))
    else $error("Keyboard config changed while locked");
  soft_rst_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && rst_s2_q && !bat_s2_q |=> !klock && !mlock &&
    kcfg_q[6:0] == $past(kcfg_q[6:0]))
    else $error("Soft reset did not clear only lock bits");
  bat_defaults_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && bat_s2_q |=> mctl_q == RST_MOUSE_CTRL && kcfg_q == RST_KBD_CFG
    && dbl_q == RST_DBL_CLICK)
    else $error("Battery reset defaults wrong");
  make_sets_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && make_hit |=> key_power_button_flag)
    else $error("Make code did not set power-button flag");
  window_bound_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ms_q == M_WAIT |-> 7'(steps_q) <= 7'(dbl_q[5:0]) + 7'd1 ||
    $changed(dbl_q))
    else $error("Double-click window overran");
endmodule

/* File: core/wake_pkg.sv */
// Package for the keyboard and mouse specific wake block
package wake_pkg;
  // -------------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] IDX_MOUSE_CTRL = 8'h5c;
  localparam logic [7:0] IDX_DBL_CLICK = 8'h5b;
  localparam logic [7:0] IDX_MAKE1 = 8'h5f;
  localparam logic [7:0] IDX_MAKE2 = 8'h60;
  localparam logic [7:0] IDX_BRK1 = 8'h61;
  localparam logic [7:0] IDX_BRK2 = 8'h62;
  localparam logic [7:0] IDX_BRK3 = 8'h63;
  localparam logic [7:0] IDX_KBD_CFG = 8'h64;
  localparam logic [7:0] IDX_STATUS = 8'h65;
  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_MOUSE_CTRL = 8'h00;
  localparam logic [7:0] RST_DBL_CLICK = 8'h0c;
  localparam logic [7:0] RST_MAKE1 = 8'he0;
  localparam logic [7:0] RST_MAKE2 = 8'h37;
  localparam logic [7:0] RST_BRK1 = 8'he0;
  localparam logic [7:0] RST_BRK2 = 8'hf0;
  localparam logic [7:0] RST_BRK3 = 8'h37;
  localparam logic [7:0] RST_KBD_CFG = 8'h6c;
  // -------------------------------------------------------------------------
  // Field positions and masks
  // -------------------------------------------------------------------------
  localparam int LOCK_BIT = 7;
  localparam int SWAP_BIT = 6;
  localparam int SPIN_BIT = 7;
  localparam logic [7:0] MOUSE_CTRL_MASK = 8'h5c;
  localparam logic [7:0] DBL_CLICK_MASK = 8'h3f;
  localparam logic [7:0] DBL_SPIN_MASK = 8'h80;
  localparam logic [7:0] KBD_CFG_MASK = 8'h7c;
  localparam logic [7:0] WILDCARD = 8'h00;
  localparam logic [7:0] PFX_EXT = 8'he0;
  localparam logic [7:0] PFX_BRK = 8'hf0;
  localparam logic [7:0] SET1_BRK_BIT = 8'h80;
  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam real CLK_NS = 10.0;
  localparam real STEP_S = 0.0859375;
  localparam real SPIN_S = 2.0;
  localparam int STEP_CYC = int'(STEP_S * 1.0e9 / CLK_NS);
  localparam int SPIN_CYC = int'(SPIN_S * 1.0e9 / CLK_NS);
  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic left;
    logic right;
    logic middle;
    logic moved;
  } mouse_evt_t;
  typedef enum logic [1:0] {
    SCAN_S1_SINGLE,
    SCAN_S1_MULTI,
    SCAN_S2_SINGLE,
    SCAN_S2_MULTI
  } scan_type_t;
endpackage

/* File: tb/kbd_mouse_partner.sv */
// Keyboard and mouse model driving the wake block's port inputs
`timescale 1ns/1ps
module kbd_mouse_partner
  import wake_pkg::*;
(
  input wire logic pclk,
  input wire logic swapped,
  output logic porta_valid,
  output logic [7:0] porta_byte,
  output logic portb_valid,
  output logic [7:0] portb_byte,
  output mouse_evt_t porta_mouse,
  output mouse_evt_t portb_mouse
);
  logic key_v;
  logic [7:0] key_b;
  mouse_evt_t ptr;
  int gap = 4;
  initial begin
    key_v = 1'b0;
    key_b = 8'h5a;
    ptr = '0;
  end
  // -------------------------------------------------------------------------
  // Keyboard on port a and mouse on port b unless exchanged
  // -------------------------------------------------------------------------
  assign porta_valid = swapped ? 1'b0 : key_v;
  assign portb_valid = swapped ? key_v : 1'b0;
  assign porta_byte = swapped ? 8'ha5 : key_b;
  assign portb_byte = swapped ? key_b : 8'ha5;
  assign porta_mouse = swapped ? ptr : '0;
  assign portb_mouse = swapped ? '0 : ptr;
  // Byte strobe, then the data line turns to the inverse
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    key_v <= 1'b1;
    key_b <= b;
    repeat (4) @(posedge pclk);
    key_v <= 1'b0;
    key_b <= ~b;
    repeat (gap) @(posedge pclk);
  endtask
  // Press held three cycles, then a pause
  task automatic click(input mouse_evt_t m, input int g);
    @(posedge pclk);
    ptr <= m;
    repeat (3) @(posedge pclk);
    ptr <= '0;
    repeat (g) @(posedge pclk);
  endtask
endmodule

/* File: tb/test_kbd_mouse_wake.sv */
// Self-checking testbench for the keyboard and mouse wake block
`timescale 1ns/1ps
module test_kbd_mouse_wake
  import wake_pkg::*;
;
  logic pclk, presetn, clk_en, bat_por, soft_rst, swapped;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pa_v, pb_v, wake_pme, flag, spin;
  logic [7:0] pa_b, pb_b;
  mouse_evt_t pa_m, pb_m;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] m1[4] = '{8'h37, 8'he0, 8'h00, 8'he0};
  logic [7:0] m2[4] = '{8'h37, 8'h37, 8'h37, 8'h00};
  logic [7:0] k2[4] = '{8'h00, 8'h37, 8'h00, 8'h5a};
  logic [7:0] k1[4] = '{8'h37, 8'he0, 8'h1c, 8'he0};
  logic [2:0] sel[8] = '{0, 1, 2, 3, 1, 5, 6, 6};
  logic [3:0] ev[8] = '{1, 8, 4, 2, 4, 8, 4, 4};
  int gp[8] = '{2, 2, 2, 2, 2, 2, 2, 40};
  logic ex[8] = '{1, 1, 1, 1, 0, 1, 1, 0};
  kbd_mouse_wake #(.STEP_CYCLES(4), .SPIN_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .bat_por(bat_por),
    .soft_rst(soft_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .porta_valid(pa_v), .porta_byte(pa_b),
    .portb_valid(pb_v), .portb_byte(pb_b), .porta_mouse(pa_m),
    .portb_mouse(pb_m), .wake_pme(wake_pme),
    .key_power_button_flag(flag), .spinup_done(spin)
  );
  kbd_mouse_partner far (
    .pclk(pclk), .swapped(swapped), .porta_valid(pa_v), .porta_byte(pa_b),
    .portb_valid(pb_v), .portb_byte(pb_b), .porta_mouse(pa_m),
    .portb_mouse(pb_m)
  );
  // -------------------------------------------------------------------------
  // Clock, timeout, verdict
  // -------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // -------------------------------------------------------------------------
  // Compares and bus access
  // -------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask
  task automatic rr(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    check(rd, {24'h00_0000, e});
  endtask
  task automatic hard_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    swapped <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic pulse(input logic bat);
    @(posedge pclk);
    bat_por <= bat;
    soft_rst <= ~bat;
    repeat (4) @(posedge pclk);
    bat_por <= 1'b0;
    soft_rst <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b, input int n);
    far.send(a);
    if (n > 1) far.send(b);
    repeat (8) @(posedge pclk);
  endtask
  // -------------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    bat_por = 1'b0;
    soft_rst = 1'b0;
    swapped = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_bit(spin, 1'b0);
    rr(IDX_MOUSE_CTRL, 8'h00);
    rr(IDX_DBL_CLICK, 8'h0c);
    rr(IDX_MAKE1, 8'he0);
    rr(IDX_MAKE2, 8'h37);
    rr(IDX_BRK1, 8'he0);
    rr(IDX_BRK2, 8'hf0);
    rr(IDX_BRK3, 8'h37);
    rr(IDX_KBD_CFG, 8'h6c);
    apb(1'b0, 12'hffc, 8'h00);
    check_bit(err, 1'b1);
    check(rd, 32'h0000_0000);
    check_bit(spin, 1'b1);
    wr(IDX_MOUSE_CTRL, 8'hfc);
    rr(IDX_MOUSE_CTRL, 8'hdc);
    wr(IDX_DBL_CLICK, 8'h3f);
    wr(IDX_MOUSE_CTRL, 8'h00);
    rr(IDX_DBL_CLICK, 8'h0c);
    rr(IDX_MOUSE_CTRL, 8'hdc);
    pulse(1'b0);
    rr(IDX_MOUSE_CTRL, 8'h5c);
    wr(IDX_DBL_CLICK, 8'hff);
    rr(IDX_DBL_CLICK, 8'hbf);
    pulse(1'b1);
    rr(IDX_MOUSE_CTRL, 8'h00);
    rr(IDX_DBL_CLICK, 8'h0c);
    wr(IDX_KBD_CFG, 8'he8);
    wr(IDX_MAKE1, 8'h11);
    wr(IDX_KBD_CFG, 8'h4c);
    rr(IDX_MAKE1, 8'he0);
    rr(IDX_KBD_CFG, 8'he8);
    pulse(1'b0);
    rr(IDX_KBD_CFG, 8'h68);
    hard_reset();
    clk_en <= 1'b0;
    keys(8'he0, 8'h37, 2);
    clk_en <= 1'b1;
    check_bit(flag, 1'b0);
    far.gap = 20;
    far.send(8'he0);
    keys(8'h12, 8'h37, 2);
    check_bit(flag, 1'b0);
    far.gap = 4;
    keys(8'he0, 8'h37, 2);
    check_bit(flag, 1'b1);
    check_bit(wake_pme, 1'b1);
    keys(8'he0, 8'hf0, 2);
    check_bit(flag, 1'b1);
    keys(8'h37, 8'h00, 1);
    check_bit(flag, 1'b0);
    wr(IDX_KBD_CFG, 8'h4c);
    keys(8'he0, 8'h37, 2);
    check_bit(flag, 1'b1);
    keys(8'h1c, 8'h00, 1);
    check_bit(flag, 1'b0);
    rr(IDX_STATUS, 8'h05);
    for (int t = 0; t < 4; t++) begin
      hard_reset();
      swapped <= t[0];
      wr(IDX_MOUSE_CTRL, {1'b0, t[0], 6'h00});
      wr(IDX_MAKE1, m1[t]);
      wr(IDX_MAKE2, m2[t]);
      wr(IDX_KBD_CFG, {4'h6, t[1:0], 2'b00});
      keys(k1[t], k2[t], t[0] + 1);
      check_bit(flag, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      hard_reset();
      wr(IDX_DBL_CLICK, 8'h03);
      wr(IDX_MOUSE_CTRL, {3'b000, sel[i], 2'b00});
      far.click(ev[i], gp[i]);
      far.click(ev[i], 8);
      check_bit(wake_pme, ex[i]);
    end
    give_verdict();
  end
endmodule
